// ==== fifo_store_mem.sv ====
`timescale 1ns/100ps
// 64 x 36 storage, one write and one registered read port
module fifo_store_mem
  import port_b_read_pkg::*;
(
  input wire logic clk_in,
  input wire logic wr_en_in,
  input wire logic [port_b_read_pkg::ADDR_W-1:0] wr_addr_in,
  input wire logic [port_b_read_pkg::DATA_W-1:0] wr_data_in,
  input wire logic rd_en_in,
  input wire logic [port_b_read_pkg::ADDR_W-1:0] rd_addr_in,
  output logic [port_b_read_pkg::DATA_W-1:0] rd_data_out
);
  logic [DATA_W-1:0] mem_q [DEPTH];

  // no reset on the array; contents are only read after a write
  always_ff @(posedge clk_in)
  begin
    if (wr_en_in)
    begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
    if (rd_en_in)
    begin
      rd_data_out <= mem_q[rd_addr_in];
    end
  end
endmodule : fifo_store_mem

// ==== port_b_read_pkg.sv ====
// Summary of operation
// - word reads: swap, then halves by endianness
// - byte reads: four swapped bytes by endianness
// - unused output lanes hold their last value
// - both size inputs high reads mailbox
// - empty only after last piece is read
// - empty clears two edges after the write edge
// - full clears next cycle after freeing read
// - location freed only on last piece
// - almost empty clears next cycle after write
// - almost empty counts whole long words
// - almost full clears after last-piece read
// - swap code sampled on new long word
// - mailbox access keeps sizing sequence intact
package port_b_read_pkg;
  localparam int DATA_W = 36;
  localparam int HALF_W = 18;
  localparam int BYTE_W = 9;
  localparam int DEPTH = 64;
  localparam int ADDR_W = 6;
  localparam int CNT_W = 7;
  localparam int BUF_CNT_W = 2;
  localparam logic [CNT_W-1:0] FULL_LEVEL = 7'h40;
  localparam logic [BUF_CNT_W-1:0] BUF_DEPTH = 2'h2;
  localparam logic [CNT_W-1:0] PTR_STEP = 7'h01;
  // bus size codes, high select bit first
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_MAILBOX = 2'h3;
  // swap codes, high select bit first
  localparam logic [1:0] SWAP_NONE = 2'h0;
  localparam logic [1:0] SWAP_REVERSE = 2'h1;
  localparam logic [1:0] SWAP_HALVES = 2'h2;
  localparam logic [1:0] SWAP_BYTES = 2'h3;
  localparam logic [1:0] POS_FIRST = 2'h0;
  localparam logic [1:0] POS_WORD_LAST = 2'h1;
  localparam logic [1:0] POS_BYTE_LAST = 2'h3;
  localparam logic [1:0] POS_STEP = 2'h1;
endpackage : port_b_read_pkg

// ==== port_b_reader.sv ====
`timescale 1ns/100ps
// port B reader; one read per call, selects held through the taking edge
module port_b_reader
  import port_b_read_pkg::*;
(
  input wire logic clk_in,
  output logic select_n_out,
  output logic write_not_read_out,
  output logic size_high_out,
  output logic size_low_out,
  output logic big_endian_out,
  output logic swap_high_out,
  output logic swap_low_out
);
  // idle bus: deselected, read direction, long size
  initial
  begin
    select_n_out = 1'b1;
    write_not_read_out = 1'b0;
    {size_high_out, size_low_out} = SIZE_LONG;
    {big_endian_out, swap_high_out, swap_low_out} = 3'h0;
  end
  // called just after an edge, returns just after the edge that takes it
  task automatic rd(input logic [1:0] sz, input logic e, input logic [1:0] sw);
    select_n_out = 1'b0;
    {size_high_out, size_low_out} = sz;
    big_endian_out = e;
    {swap_high_out, swap_low_out} = sw;
    @(posedge clk_in);
    #1;
  endtask : rd
  task automatic idle();
    select_n_out = 1'b1;
  endtask : idle
endmodule : port_b_reader

// ==== port_b_sized_swap_read.sv ====
`timescale 1ns/100ps
module port_b_sized_swap_read
  import port_b_read_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic port_a_select_n_in,
  input wire logic port_a_write_not_read_in,
  input wire logic port_a_mailbox_select_in,
  input wire logic [port_b_read_pkg::DATA_W-1:0] port_a_data_in,
  input wire logic port_b_select_n_in,
  input wire logic port_b_write_not_read_in,
  input wire logic bus_size_select_high_in,
  input wire logic bus_size_select_low_in,
  input wire logic big_endian_select_in,
  input wire logic swap_select_high_in,
  input wire logic swap_select_low_in,
  input wire logic [port_b_read_pkg::DATA_W-1:0] mailbox_a_to_b_in,
  input wire logic [port_b_read_pkg::CNT_W-1:0] almost_empty_level_in,
  input wire logic [port_b_read_pkg::CNT_W-1:0] almost_full_level_in,
  output logic [port_b_read_pkg::DATA_W-1:0] port_b_data_out,
  output logic empty_flag_n_out,
  output logic full_flag_n_out,
  output logic almost_empty_flag_n_out,
  output logic almost_full_flag_n_out
);
  import port_b_read_pkg::*;

  function automatic logic [DATA_W-1:0] swap_bytes(input logic [DATA_W-1:0] w,
                                                  input logic [1:0] code);
    logic [BYTE_W-1:0] a;
    logic [BYTE_W-1:0] b;
    logic [BYTE_W-1:0] c;
    logic [BYTE_W-1:0] d;
    a = w[3*BYTE_W +: BYTE_W];
    b = w[2*BYTE_W +: BYTE_W];
    c = w[BYTE_W +: BYTE_W];
    d = w[0 +: BYTE_W];
    unique case (code)
      SWAP_NONE: swap_bytes = {a, b, c, d};
      SWAP_REVERSE: swap_bytes = {d, c, b, a};
      SWAP_HALVES: swap_bytes = {c, d, a, b};
      SWAP_BYTES: swap_bytes = {b, a, d, c};
    endcase
  endfunction : swap_bytes

  function automatic logic [BYTE_W-1:0] pick_byte(input logic [DATA_W-1:0] w,
                                                 input logic [1:0] idx);
    pick_byte = w[idx*BYTE_W +: BYTE_W];
  endfunction : pick_byte

  logic [CNT_W-1:0] wr_ptr_q;
  logic [CNT_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] level_q;
  logic [CNT_W-1:0] level_d;
  logic inflight_q;
  logic [BUF_CNT_W-1:0] buf_cnt_q;
  logic [DATA_W-1:0] buf0_q;
  logic [DATA_W-1:0] buf1_q;
  logic [DATA_W-1:0] cur_q;
  logic [1:0] pos_q;
  logic [1:0] size_q;
  logic big_q;
  logic [DATA_W-1:0] out_q;
  logic [DATA_W-1:0] out_d;
  logic full_n_q;
  logic ae_n_q;
  logic af_n_q;
  logic [DATA_W-1:0] mem_rd_data;

  // port A write qualification; full blocks writes
  wire write_fire = !port_a_select_n_in && port_a_write_not_read_in &&
                    !port_a_mailbox_select_in && full_n_q;
  wire [1:0] size_in = {bus_size_select_high_in, bus_size_select_low_in};
  wire [1:0] swap_in = {swap_select_high_in, swap_select_low_in};
  wire b_read = !port_b_select_n_in && !port_b_write_not_read_in;
  wire mailbox_read = b_read && (size_in == SIZE_MAILBOX);

  // prefetch from storage into the two-entry buffer
  wire mem_has = (wr_ptr_q != rd_ptr_q);
  wire buf_in_ready = (buf_cnt_q < BUF_DEPTH);
  wire buf_in_valid = inflight_q;
  wire buf_push = buf_in_valid && buf_in_ready;
  // space counted ahead for the word still in flight, so no push is ever refused
  wire [BUF_CNT_W:0] buf_claim = {1'b0, buf_cnt_q} + {2'h0, inflight_q};
  wire mem_issue = mem_has && buf_in_ready && (buf_claim < {1'b0, BUF_DEPTH});
  wire buf_out_valid = (buf_cnt_q != 2'h0);

  // sizing state: new long word only at position zero
  wire at_first = (pos_q == POS_FIRST);
  wire fifo_read = b_read && !mailbox_read && buf_out_valid;
  wire [1:0] eff_size = at_first ? size_in : size_q;
  wire eff_big = at_first ? big_endian_select_in : big_q;
  wire [DATA_W-1:0] src_word = at_first ? swap_bytes(buf0_q, swap_in) : cur_q;
  wire last_piece = (eff_size == SIZE_LONG) ||
                    ((eff_size == SIZE_WORD) && (pos_q == POS_WORD_LAST)) ||
                    ((eff_size == SIZE_BYTE) && (pos_q == POS_BYTE_LAST));
  wire buf_out_ready = fifo_read && last_piece;
  wire buf_pop = buf_out_valid && buf_out_ready;
  wire [1:0] big_idx = POS_BYTE_LAST - pos_q;
  wire [HALF_W-1:0] upper_half = src_word[DATA_W-1:HALF_W];
  wire [HALF_W-1:0] lower_half = src_word[HALF_W-1:0];
  wire second_word = (pos_q == POS_WORD_LAST);

  // output lane selection; lanes outside the chosen size keep their bits
  always_comb
  begin
    out_d = out_q;
    if (mailbox_read)
    begin
      out_d = mailbox_a_to_b_in;
    end
    else if (fifo_read)
    begin
      unique case (eff_size)
        SIZE_WORD:
        begin
          if (eff_big)
          begin
            out_d[DATA_W-1:HALF_W] = second_word ? lower_half : upper_half;
          end
          else
          begin
            out_d[HALF_W-1:0] = second_word ? upper_half : lower_half;
          end
        end
        SIZE_BYTE:
        begin
          if (eff_big)
          begin
            out_d[DATA_W-1 -: BYTE_W] = pick_byte(src_word, big_idx);
          end
          else
          begin
            out_d[BYTE_W-1:0] = pick_byte(src_word, pos_q);
          end
        end
        default:
        begin
          out_d = src_word;
        end
      endcase
    end
  end

  // occupancy: counts long words until their last piece is read
  always_comb
  begin
    level_d = level_q;
    if (write_fire && !buf_pop)
    begin
      level_d = level_q + PTR_STEP;
    end
    else if (!write_fire && buf_pop)
    begin
      level_d = level_q - PTR_STEP;
    end
  end

  fifo_store_mem u_store (
    .clk_in(clk_in),
    .wr_en_in(write_fire),
    .wr_addr_in(wr_ptr_q[ADDR_W-1:0]),
    .wr_data_in(port_a_data_in),
    .rd_en_in(mem_issue),
    .rd_addr_in(rd_ptr_q[ADDR_W-1:0]),
    .rd_data_out(mem_rd_data)
  );

  // pointers, in-flight marker and level
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      inflight_q <= 1'b0;
      level_q <= '0;
    end
    else
    begin
      if (write_fire)
      begin
        wr_ptr_q <= wr_ptr_q + PTR_STEP;
      end
      if (mem_issue)
      begin
        rd_ptr_q <= rd_ptr_q + PTR_STEP;
      end
      inflight_q <= mem_issue;
      level_q <= level_d;
    end
  end

  // two-entry buffer: head in buf0, shift on pop
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      buf_cnt_q <= '0;
      buf0_q <= '0;
      buf1_q <= '0;
    end
    else
    begin
      if (buf_pop)
      begin
        buf0_q <= buf1_q;
      end
      if (buf_push)
      begin
        if ((buf_cnt_q == 2'h0) || ((buf_cnt_q == 2'h1) && buf_pop))
        begin
          buf0_q <= mem_rd_data;
        end
        else
        begin
          buf1_q <= mem_rd_data;
        end
      end
      buf_cnt_q <= buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // sizing position, latched size, endianness and swapped word
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pos_q <= POS_FIRST;
      size_q <= SIZE_LONG;
      big_q <= 1'b0;
      cur_q <= '0;
      out_q <= '0;
    end
    else
    begin
      out_q <= out_d;
      if (fifo_read)
      begin
        size_q <= eff_size;
        big_q <= eff_big;
        cur_q <= src_word;
        pos_q <= last_piece ? POS_FIRST : pos_q + POS_STEP;
      end
    end
  end

  // status flags registered from the next level, so they move on the same edge as the level
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      full_n_q <= 1'b1;
      ae_n_q <= 1'b0;
      af_n_q <= 1'b1;
    end
    else
    begin
      full_n_q <= (level_d != FULL_LEVEL);
      ae_n_q <= (level_d > almost_empty_level_in);
      af_n_q <= (level_d < (FULL_LEVEL - almost_full_level_in));
    end
  end

  // empty follows the buffer head, which leaves only on a last piece
  assign empty_flag_n_out = buf_out_valid;
  assign full_flag_n_out = full_n_q;
  assign almost_empty_flag_n_out = ae_n_q;
  assign almost_full_flag_n_out = af_n_q;
  assign port_b_data_out = out_q;
endmodule : port_b_sized_swap_read

// ==== port_b_sized_swap_read_asserts.sv ====
`timescale 1ns/100ps
// port-level checks on the read path; sees only the block's pins
module port_b_sized_swap_read_asserts
  import port_b_read_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic port_a_select_n_in,
  input wire logic port_a_write_not_read_in,
  input wire logic port_a_mailbox_select_in,
  input wire logic port_b_select_n_in,
  input wire logic port_b_write_not_read_in,
  input wire logic bus_size_select_high_in,
  input wire logic bus_size_select_low_in,
  input wire logic big_endian_select_in,
  input wire logic [port_b_read_pkg::DATA_W-1:0] mailbox_a_to_b_in,
  input wire logic [port_b_read_pkg::DATA_W-1:0] port_b_data_out,
  input wire logic empty_flag_n_out,
  input wire logic full_flag_n_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // accesses decoded as the block should take them
  wire rd = !port_b_select_n_in && !port_b_write_not_read_in;
  wire [1:0] sz = {bus_size_select_high_in, bus_size_select_low_in};
  wire mb = rd && sz == SIZE_MAILBOX;
  wire frd = rd && !mb && empty_flag_n_out;
  wire wr = !port_a_select_n_in && port_a_write_not_read_in && !port_a_mailbox_select_in
    && full_flag_n_out;
  AST_MBOX_READ: assert property (mb
    |=> port_b_data_out == $past(mailbox_a_to_b_in))
    else $error("mailbox read gave wrong data");
  AST_HOLD_IDLE: assert property (port_b_select_n_in |=> $stable(port_b_data_out))
    else $error("output moved without a read");
  AST_EMPTY_REFUSE: assert property (rd && !mb && !empty_flag_n_out
    |=> $stable(port_b_data_out))
    else $error("read while empty changed output");
  AST_EMPTY_RISE: assert property (wr ##1 !frd [*3] |=> empty_flag_n_out)
    else $error("empty flag late after write");
  AST_FULL_HOLD: assert property (!full_flag_n_out && !frd && !$past(frd)
    |=> !full_flag_n_out)
    else $error("full cleared without a read");
  AST_BYTE_BIG: assert property (frd && sz == SIZE_BYTE && big_endian_select_in
    |=> $stable(port_b_data_out[26:0]))
    else $error("byte read disturbed low lanes");
  AST_BYTE_LITTLE: assert property (frd && sz == SIZE_BYTE && !big_endian_select_in
    |=> $stable(port_b_data_out[35:9]))
    else $error("byte read disturbed high lanes");
  AST_WORD_BIG: assert property (frd && sz == SIZE_WORD && big_endian_select_in
    |=> $stable(port_b_data_out[17:0]))
    else $error("word read disturbed low half");
  AST_WORD_LITTLE: assert property (frd && sz == SIZE_WORD && !big_endian_select_in
    |=> $stable(port_b_data_out[35:18]))
    else $error("word read disturbed high half");
  COV_MBOX: cover property (mb);
  COV_FULL_READ: cover property (!full_flag_n_out ##1 frd);
  COV_BYTE: cover property (frd && sz == SIZE_BYTE);
endmodule : port_b_sized_swap_read_asserts
bind port_b_sized_swap_read port_b_sized_swap_read_asserts i_chk (.clk_in, .rst_n_in,
  .port_a_select_n_in, .port_a_write_not_read_in, .port_a_mailbox_select_in,
  .port_b_select_n_in, .port_b_write_not_read_in, .bus_size_select_high_in,
  .bus_size_select_low_in, .big_endian_select_in, .mailbox_a_to_b_in, .port_b_data_out,
  .empty_flag_n_out, .full_flag_n_out);

// ==== tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  import port_b_read_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic a_sel_n = 1'b1;
  logic [DATA_W-1:0] a_data = 36'h0_0000_0000;
  logic [DATA_W-1:0] mbox = 36'h0_0000_0000;
  logic b_sel_n, b_wnr, sz_hi, sz_lo, be, sw_hi, sw_lo;
  logic [DATA_W-1:0] dout;
  logic ef_n, ff_n, ae_n, af_n;
  int error_cnt = 0;
  int total_checks = 0;
  always #2 clk_in = ~clk_in;
  // levels tied: empty-ish at 2 words, full-ish 4 below the top
  port_b_sized_swap_read i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .port_a_select_n_in(a_sel_n), .port_a_write_not_read_in(1'b1),
    .port_a_mailbox_select_in(1'b0), .port_a_data_in(a_data),
    .port_b_select_n_in(b_sel_n), .port_b_write_not_read_in(b_wnr),
    .bus_size_select_high_in(sz_hi), .bus_size_select_low_in(sz_lo),
    .big_endian_select_in(be), .swap_select_high_in(sw_hi), .swap_select_low_in(sw_lo),
    .mailbox_a_to_b_in(mbox), .almost_empty_level_in(7'h02), .almost_full_level_in(7'h04),
    .port_b_data_out(dout), .empty_flag_n_out(ef_n), .full_flag_n_out(ff_n),
    .almost_empty_flag_n_out(ae_n), .almost_full_flag_n_out(af_n));
  port_b_reader i_rdr (.clk_in(clk_in), .select_n_out(b_sel_n), .write_not_read_out(b_wnr),
    .size_high_out(sz_hi), .size_low_out(sz_lo), .big_endian_out(be),
    .swap_high_out(sw_hi), .swap_low_out(sw_lo));
  task automatic chk(input string what, input logic [DATA_W-1:0] got,
    input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // write held low; caller releases, so back-to-back writes never glitch
  task automatic wr(input logic [DATA_W-1:0] d);
    a_sel_n = 1'b0;
    a_data = d;
    @(posedge clk_in);
    #1;
  endtask : wr
  function automatic logic [DATA_W-1:0] swp(input logic [DATA_W-1:0] d, input logic [1:0] c);
    case (c)
      SWAP_REVERSE: return {d[8:0], d[17:9], d[26:18], d[35:27]};
      SWAP_HALVES: return {d[17:0], d[35:18]};
      SWAP_BYTES: return {d[26:18], d[35:27], d[8:0], d[17:9]};
      default: return d;
    endcase
  endfunction : swp
  // all swaps and endians; swap pins flipped and a mailbox read mid word
  task automatic t_sized(input logic [1:0] sz, input int n);
    int w;
    logic [DATA_W-1:0] m, sv, p, ex, wd;
    w = DATA_W / n;
    m = {DATA_W{1'b1}} >> (DATA_W - w);
    for (int e = 0; e < 2; e++)
      for (int s = 0; s < 4; s++)
      begin
        wd = 36'h1_2345_6789 + 36'(s * 3 + e);
        wr(wd);
        a_sel_n = 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        chk("empty after write", ef_n, 1'b1);
        sv = swp(wd, s[1:0]);
        for (int k = 0; k < n; k++)
        begin
          p = (e ? sv >> (DATA_W - w * (k + 1)) : sv >> (w * k)) & m;
          ex = e ? (dout & ~(m << (DATA_W - w))) | (p << (DATA_W - w)) : (dout & ~m) | p;
          i_rdr.rd(sz, e[0], k == 0 ? s[1:0] : ~s[1:0]);
          chk("sized data", dout, ex);
          chk("empty mid word", ef_n, 1'(k < n - 1));
          if (k == 0 && n > 1)
          begin
            mbox = ~wd;
            i_rdr.rd(SIZE_MAILBOX, 1'b0, SWAP_REVERSE);
            chk("mailbox data", dout, ~wd);
          end
        end
        i_rdr.idle();
      end
  endtask : t_sized
  // fill until writes are refused, then drain with the reader stalling
  task automatic t_full();
    logic [DATA_W-1:0] last;
    for (int i = 0; i < DEPTH; i++)
      wr(36'(i));
    a_sel_n = 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    chk("full", ff_n, 1'b0);
    chk("almost full", af_n, 1'b0);
    chk("almost empty", ae_n, 1'b1);
    wr(36'hF_FFFF_FFFF);
    a_sel_n = 1'b1;
    i_rdr.rd(SIZE_WORD, 1'b1, SWAP_NONE);
    i_rdr.idle();
    @(posedge clk_in);
    #1;
    chk("full after half", ff_n, 1'b0);
    i_rdr.rd(SIZE_WORD, 1'b1, SWAP_NONE);
    i_rdr.idle();
    chk("full same edge", ff_n, 1'b1);
    @(posedge clk_in);
    #1;
    chk("full freed", ff_n, 1'b1);
    for (int i = 1; i < DEPTH; i++)
    begin
      for (int t = 0; t < 8 && ef_n !== 1'b1; t++)
      begin
        @(posedge clk_in);
        #1;
      end
      i_rdr.rd(SIZE_LONG, 1'b0, SWAP_NONE);
      chk("drained data", dout, 36'(i));
      i_rdr.idle();
      @(posedge clk_in);
      #1;
    end
    chk("drained empty", ef_n, 1'b0);
    chk("drained almost empty", ae_n, 1'b0);
    chk("drained almost full", af_n, 1'b1);
    last = dout;
    i_rdr.rd(SIZE_LONG, 1'b0, SWAP_NONE);
    i_rdr.idle();
    chk("refused read", dout, last);
  endtask : t_full
  initial
  begin
    repeat (5) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    chk("reset data", dout, 36'h0_0000_0000);
    chk("reset empty", ef_n, 1'b0);
    t_sized(SIZE_LONG, 1);
    t_sized(SIZE_WORD, 2);
    t_sized(SIZE_BYTE, 4);
    t_full();
    finish_test();
  end
  // hang guard, well past the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    finish_test();
  end
endmodule : tb_top
